// File: hdl/pemask_pkg.sv
/*
  Package for the pin edge interrupt masking block: register offsets,
  field positions, reset values and widths.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package pemask_pkg;
  localparam int PEMASK_NPINS = 10;
  localparam int PEMASK_ADDR_W = 12;
  // Printed offsets are not all multiples of four: they are indices
  localparam logic [7:0] PEMASK_IDX_FALL18 = 8'h4f;
  localparam logic [7:0] PEMASK_IDX_RISE18 = 8'h50;
  localparam logic [7:0] PEMASK_IDX_PIN910 = 8'h51;
  localparam logic [7:0] PEMASK_IDX_INSTAT1 = 8'h60;
  localparam logic [7:0] PEMASK_IDX_INSTAT2 = 8'h61;
  localparam logic [7:0] PEMASK_IDX_IRQSTAT = 8'h62;
  localparam logic [7:0] PEMASK_IDX_IRQMASK = 8'h63;
  localparam logic [7:0] PEMASK_IDX_NVMLOAD = 8'h64;
  localparam logic [7:0] PEMASK_RST_MASK = 8'h00;
  localparam logic [3:0] PEMASK_RST_IRQMASK = 4'h0;
  // Bits of the pins nine and ten register
  localparam int PEMASK_B_FALL9 = 0;
  localparam int PEMASK_B_FALL10 = 1;
  localparam int PEMASK_B_RISE9 = 3;
  localparam int PEMASK_B_RISE10 = 4;
  // Bits of the summary event status register
  localparam int PEMASK_EV_FALL18 = 0;
  localparam int PEMASK_EV_RISE18 = 1;
  localparam int PEMASK_EV_FALL910 = 2;
  localparam int PEMASK_EV_RISE910 = 3;
  localparam logic [1:0] PEMASK_RESP_OKAY = 2'b00;
  localparam logic [1:0] PEMASK_RESP_SLVERR = 2'b10;

  function automatic logic [7:0] pemask_idx(input logic [PEMASK_ADDR_W-1:0] a);
    return a[9:2];
  endfunction
endpackage

// File: hdl/pemask_reg_if.sv
/*
  Register access bundle between the bus slave and the mask core.
  Assumes both ends run on aclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface pemask_reg_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;
  modport slave (output wr_en, rd_en, idx, wdata, input rdata, hit);
  modport core (input wr_en, rd_en, idx, wdata, output rdata, hit);
endinterface
`default_nettype wire

// File: hdl/pemask_axil.sv
/*
  AXI4-Lite slave turning bus cycles into one-cycle register strobes.
  Assumes one outstanding write and one outstanding read.
*/
`timescale 1ns/100ps
`default_nettype none
module pemask_axil
  import pemask_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [PEMASK_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [PEMASK_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side
  pemask_reg_if.slave rif
);
  logic aw_held_r;
  logic w_held_r;
  logic [PEMASK_ADDR_W-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic rd_phase_r;
  logic [PEMASK_ADDR_W-1:0] araddr_r;
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire wr_go = aw_held_r && w_held_r && !bvalid;
  wire rd_go = rd_phase_r;

  assign awready = !aw_held_r && !bvalid;
  assign wready = !w_held_r && !bvalid;
  assign arready = !rd_phase_r && !rvalid;
  assign rif.wr_en = wr_go && wlane_r && rif.hit;
  assign rif.rd_en = rd_go && !wr_go;
  assign rif.idx = wr_go ? pemask_idx(awaddr_r) : pemask_idx(araddr_r);
  assign rif.wdata = wdata_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= PEMASK_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= wdata[7:0];
        wlane_r <= wstrb[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= rif.hit ? PEMASK_RESP_OKAY : PEMASK_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read waits one cycle if a write strobe owns the index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_phase_r <= 1'b0;
      araddr_r <= '0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= PEMASK_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        rd_phase_r <= 1'b1;
        araddr_r <= araddr;
      end
      if (rd_go && !wr_go) begin
        rd_phase_r <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h000000, rif.rdata};
        rresp <= rif.hit ? PEMASK_RESP_OKAY : PEMASK_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // pemask_axil
`default_nettype wire

// File: hdl/pemask_edge.sv
/*
  Edge detector for the ten pins and live input status.
  Assumes pin inputs are synchronous to aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module pemask_edge
  import pemask_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins
  input wire logic [PEMASK_NPINS-1:0] pin_in,
  // Detected edges and status
  output logic [PEMASK_NPINS-1:0] fall_ev,
  output logic [PEMASK_NPINS-1:0] rise_ev,
  output logic [PEMASK_NPINS-1:0] level_r
);
  logic primed_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= '0;
      primed_r <= 1'b0;
    end else begin
      level_r <= pin_in;
      primed_r <= 1'b1;
    end
  end
  // No edges until a first sample is held
  assign fall_ev = primed_r ? (level_r & ~pin_in) : '0;
  assign rise_ev = primed_r ? (~level_r & pin_in) : '0;
endmodule // pemask_edge
`default_nettype wire

// File: hdl/pemask_top.sv
/*
  Pin edge interrupt masking block: falling and rising edge masks for
  ten pins, live input status, sticky event status with a read clear,
  and one level interrupt output.
  Assumes an AXI4-Lite master on aclk and nonvolatile defaults that are
  valid while nvm_load is pulsed after reset.
*/
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Unmasked falling edge raises interrupt; masked none
// - Unmasked rising edge raises interrupt; masked none
// - Masks never alter pins one-eight status
// - Masks never alter pins nine-ten status
// - Falling mask of pin n at bit n-1
// - Rising mask register 0x50, reset 0x00
// - Pins nine-ten register 0x51, documented bit layout
// - Reserved bits there read/write, reset zero
// - Mask defaults load from nonvolatile memory
module pemask_top
  import pemask_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [PEMASK_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [PEMASK_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Nonvolatile defaults
  input wire logic nvm_load,
  input wire logic [7:0] nvm_fall18,
  input wire logic [7:0] nvm_rise18,
  input wire logic [7:0] nvm_pin910,
  // Pins and interrupt
  input wire logic [PEMASK_NPINS-1:0] pin_in,
  output logic [PEMASK_NPINS-1:0] pin_edge_irq,
  output logic irq
);
  pemask_reg_if rif ();
  logic [PEMASK_NPINS-1:0] fall_ev;
  logic [PEMASK_NPINS-1:0] rise_ev;
  logic [PEMASK_NPINS-1:0] level_r;
  logic [7:0] fall18_r;
  logic [7:0] rise18_r;
  logic [7:0] pin910_r;
  logic [3:0] evstat_r;
  logic [3:0] evstat_nxt;
  logic [3:0] evmask_r;
  logic [PEMASK_NPINS-1:0] fall_msk;
  logic [PEMASK_NPINS-1:0] rise_msk;
  logic [PEMASK_NPINS-1:0] fall_pass;
  logic [PEMASK_NPINS-1:0] rise_pass;
  logic [3:0] ev_set;

  pemask_axil u_axil (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rif(rif)
  );

  pemask_edge u_edge (
    .aclk(aclk), .aresetn(aresetn), .pin_in(pin_in),
    .fall_ev(fall_ev), .rise_ev(rise_ev), .level_r(level_r)
  );

  // Per-pin mask vectors from the three registers
  assign fall_msk = {pin910_r[PEMASK_B_FALL10], pin910_r[PEMASK_B_FALL9], fall18_r};
  assign rise_msk = {pin910_r[PEMASK_B_RISE10], pin910_r[PEMASK_B_RISE9], rise18_r};
  assign fall_pass = fall_ev & ~fall_msk;
  assign rise_pass = rise_ev & ~rise_msk;

  assign ev_set[PEMASK_EV_FALL18] = |fall_pass[7:0];
  assign ev_set[PEMASK_EV_RISE18] = |rise_pass[7:0];
  assign ev_set[PEMASK_EV_FALL910] = |fall_pass[9:8];
  assign ev_set[PEMASK_EV_RISE910] = |rise_pass[9:8];

  wire sel_fall18 = rif.idx == PEMASK_IDX_FALL18;
  wire sel_rise18 = rif.idx == PEMASK_IDX_RISE18;
  wire sel_pin910 = rif.idx == PEMASK_IDX_PIN910;
  wire sel_in1 = rif.idx == PEMASK_IDX_INSTAT1;
  wire sel_in2 = rif.idx == PEMASK_IDX_INSTAT2;
  wire sel_stat = rif.idx == PEMASK_IDX_IRQSTAT;
  wire sel_imask = rif.idx == PEMASK_IDX_IRQMASK;
  wire sel_nvm = rif.idx == PEMASK_IDX_NVMLOAD;
  wire stat_rd = rif.rd_en && sel_stat;
  wire nvm_go = nvm_load || (rif.wr_en && sel_nvm && rif.wdata[0]);

  assign rif.hit = sel_fall18 | sel_rise18 | sel_pin910 | sel_in1 | sel_in2
                 | sel_stat | sel_imask | sel_nvm;
  // Status comes straight from the pin samples, never from masks
  assign rif.rdata = sel_fall18 ? fall18_r
                   : sel_rise18 ? rise18_r
                   : sel_pin910 ? pin910_r
                   : sel_in1 ? level_r[7:0]
                   : sel_in2 ? {6'h00, level_r[9:8]}
                   : sel_stat ? {4'h0, evstat_r}
                   : sel_imask ? {4'h0, evmask_r}
                   : 8'h00;

  // Set wins over the read clear
  assign evstat_nxt = (stat_rd ? 4'h0 : evstat_r) | ev_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fall18_r <= PEMASK_RST_MASK;
      rise18_r <= PEMASK_RST_MASK;
      pin910_r <= PEMASK_RST_MASK;
    end else if (nvm_go) begin
      fall18_r <= nvm_fall18;
      rise18_r <= nvm_rise18;
      pin910_r <= nvm_pin910;
    end else if (rif.wr_en) begin
      if (sel_fall18) fall18_r <= rif.wdata;
      if (sel_rise18) rise18_r <= rif.wdata;
      if (sel_pin910) pin910_r <= rif.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evstat_r <= 4'h0;
      evmask_r <= PEMASK_RST_IRQMASK;
      pin_edge_irq <= '0;
    end else begin
      evstat_r <= evstat_nxt;
      pin_edge_irq <= fall_pass | rise_pass;
      if (rif.wr_en && sel_imask) evmask_r <= rif.wdata[3:0];
    end
  end

  assign irq = |(evstat_r & ~evmask_r);

  // Checks
  sequence s_fall_unmasked(int i);
    fall_ev[i] && !fall_msk[i];
  endsequence

  chk_fall_mask_block: assert property (@(posedge aclk) disable iff (!aresetn)
    (fall_ev[0] && fall_msk[0]) |=> !pin_edge_irq[0])
    else $error("masked falling edge raised pin event");
  chk_fall_pass_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    s_fall_unmasked(3) ##0 !stat_rd |=> pin_edge_irq[3] && evstat_r[PEMASK_EV_FALL18])
    else $error("unmasked falling edge lost");
  chk_rise_mask_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    rise_ev[9] |=> pin_edge_irq[9] == !$past(rise_msk[9]) || $past(fall_ev[9]))
    else $error("rising edge gating wrong");
  chk_status_live: assert property (@(posedge aclk) disable iff (!aresetn)
    rif.rd_en && sel_in1 |-> rif.rdata == level_r[7:0])
    else $error("pin status not live");
  chk_status_hi: assert property (@(posedge aclk) disable iff (!aresetn)
    rif.rd_en && sel_in2 |-> rif.rdata[1:0] == level_r[9:8])
    else $error("pin nine ten status wrong");
  chk_fall_bitpos: assert property (@(posedge aclk) disable iff (!aresetn)
    rif.wr_en && sel_fall18 && !nvm_go |=> fall_msk[7:0] == $past(rif.wdata))
    else $error("falling mask bit position wrong");
  chk_rise_write: assert property (@(posedge aclk) disable iff (!aresetn)
    rif.wr_en && sel_rise18 && !nvm_go |=> rise_msk[7:0] == $past(rif.wdata))
    else $error("rising mask write wrong");
  chk_pin910_layout: assert property (@(posedge aclk) disable iff (!aresetn)
    rif.wr_en && sel_pin910 && !nvm_go |=> rise_msk[9] == $past(rif.wdata[4])
      && fall_msk[8] == $past(rif.wdata[0]) && pin910_r == $past(rif.wdata))
    else $error("pins nine ten layout wrong");
  chk_nvm_default: assert property (@(posedge aclk) disable iff (!aresetn)
    nvm_load |=> fall18_r == $past(nvm_fall18) && pin910_r == $past(nvm_pin910))
    else $error("nonvolatile default not loaded");
  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (|ev_set) && !(|evmask_r) |=> irq [*2] or (stat_rd ##1 1'b1))
    else $error("interrupt not raised");
endmodule // pemask_top
`default_nettype wire

// File: test/pemask_pin_model.sv
/*
  Model of the ten external pins: levels requested by the bench are
  launched onto the pins at the next rising clock edge.
  Assumes the pins are sampled synchronously to aclk by the block.
*/
`timescale 1ns/100ps
`default_nettype none
module pemask_pin_model
  import pemask_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Requested levels and pins
  input wire logic [PEMASK_NPINS-1:0] level_req,
  output logic [PEMASK_NPINS-1:0] pin_in
);
  initial pin_in = '1;
  always @(posedge aclk) begin
    pin_in <= level_req;
  end
endmodule // pemask_pin_model
`default_nettype wire

// File: test/pin_edge_irq_masking_test.sv
/*
  Self-checking bench for the pin edge interrupt masking block.
  Assumes the design package and the pin model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_edge_irq_masking_test;
  import pemask_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic nvm_load = 1'b0;
  logic [7:0] nvm_fall18 = '0, nvm_rise18 = '0, nvm_pin910 = '0;
  logic [9:0] level_req = '1, pin_in, pin_edge_irq, seen;
  logic [1:0] resp;
  int n_mismatch = 0, checks = 0;

  always #50 aclk = ~aclk;

  pemask_pin_model i_pemask_pin_model (.aclk(aclk), .level_req(level_req), .pin_in(pin_in));
  pemask_top i_pemask_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .nvm_load(nvm_load), .nvm_fall18(nvm_fall18),
    .nvm_rise18(nvm_rise18), .nvm_pin910(nvm_pin910), .pin_in(pin_in),
    .pin_edge_irq(pin_edge_irq), .irq(irq));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Write one register; entered and left just after a rising edge
  task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic ah, wh, bh;
    n = 0;
    bh = 1'b0;
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh && n < 50) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      n++;
    end
    if (!bh) begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ah, rh;
    n = 0;
    rh = 1'b0;
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh && n < 50) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      n++;
    end
    if (!rh) begin
      n_mismatch++;
      summarize();
    end
  endtask

  function automatic logic [31:0] z(input logic [7:0] v);
    return {24'h0, v};
  endfunction

  task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] d;
    rd(i, d, resp);
    chk(d, z(e));
    chk(z({6'h0, resp}), z({6'h0, PEMASK_RESP_OKAY}));
  endtask

  // Move pins and gather edge pulses over a few cycles
  task automatic ev(input logic [9:0] to);
    seen = '0;
    level_req <= to;
    // Sample between edges, where the registered pulse is settled
    repeat (5) begin
      @(negedge aclk);
      seen = seen | pin_edge_irq;
    end
    @(posedge aclk);
  endtask

  task automatic t_reset();
    rdchk(PEMASK_IDX_FALL18, 8'h00);
    rdchk(PEMASK_IDX_RISE18, 8'h00);
    rdchk(PEMASK_IDX_PIN910, 8'h00);
    chk(z({7'h0, irq}), z(8'h00));
  endtask

  task automatic t_regs();
    wr(PEMASK_IDX_FALL18, 8'h3c, resp);
    wr(PEMASK_IDX_RISE18, 8'hc3, resp);
    wr(PEMASK_IDX_PIN910, 8'he4, resp);
    rdchk(PEMASK_IDX_FALL18, 8'h3c);
    rdchk(PEMASK_IDX_RISE18, 8'hc3);
    rdchk(PEMASK_IDX_PIN910, 8'he4);
    // Write without the low byte lane leaves the register alone
    wstrb <= 4'he;
    wr(PEMASK_IDX_FALL18, 8'hff, resp);
    wstrb <= 4'hf;
    rdchk(PEMASK_IDX_FALL18, 8'h3c);
    wr(8'h70, 8'h11, resp);
    chk(z({6'h0, resp}), z({6'h0, PEMASK_RESP_SLVERR}));
  endtask

  task automatic t_nvm();
    nvm_fall18 <= 8'h81;
    nvm_rise18 <= 8'h42;
    nvm_pin910 <= 8'hb5;
    nvm_load <= 1'b1;
    @(posedge aclk);
    nvm_load <= 1'b0;
    @(posedge aclk);
    rdchk(PEMASK_IDX_FALL18, 8'h81);
    rdchk(PEMASK_IDX_RISE18, 8'h42);
    rdchk(PEMASK_IDX_PIN910, 8'hb5);
    // Reload requested through the register bus
    wr(PEMASK_IDX_FALL18, 8'h00, resp);
    wr(PEMASK_IDX_NVMLOAD, 8'h01, resp);
    rdchk(PEMASK_IDX_FALL18, 8'h81);
  endtask

  task automatic t_edges();
    logic [31:0] d;
    wr(PEMASK_IDX_FALL18, 8'h01, resp);
    wr(PEMASK_IDX_RISE18, 8'h80, resp);
    wr(PEMASK_IDX_PIN910, 8'h01, resp);
    rd(PEMASK_IDX_IRQSTAT, d, resp);
    ev(10'h000);
    chk(z({6'h0, seen[9:8]}), z(8'h02));
    chk(z(seen[7:0]), z(8'hfe));
    rdchk(PEMASK_IDX_INSTAT1, 8'h00);
    rdchk(PEMASK_IDX_INSTAT2, 8'h00);
    chk(z({7'h0, irq}), z(8'h01));
    rdchk(PEMASK_IDX_IRQSTAT, 8'h05);
    repeat (2) @(posedge aclk);
    chk(z({7'h0, irq}), z(8'h00));
    wr(PEMASK_IDX_IRQMASK, 8'h0f, resp);
    wr(PEMASK_IDX_PIN910, 8'h10, resp);
    ev(10'h3ff);
    chk(z({6'h0, seen[9:8]}), z(8'h01));
    chk(z(seen[7:0]), z(8'h7f));
    chk(z({7'h0, irq}), z(8'h00));
    rdchk(PEMASK_IDX_INSTAT1, 8'hff);
    rdchk(PEMASK_IDX_INSTAT2, 8'h03);
    // Changing masks with steady pins leaves the status alone
    wr(PEMASK_IDX_FALL18, 8'hff, resp);
    wr(PEMASK_IDX_PIN910, 8'h1b, resp);
    rdchk(PEMASK_IDX_INSTAT1, 8'hff);
    rdchk(PEMASK_IDX_INSTAT2, 8'h03);
    wr(PEMASK_IDX_IRQMASK, 8'h00, resp);
    repeat (2) @(posedge aclk);
    chk(z({7'h0, irq}), z(8'h01));
    rdchk(PEMASK_IDX_IRQSTAT, 8'h0a);
  endtask

  // Reset in mid-run with pins high: masks clear, no false edge
  task automatic t_midreset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(z({7'h0, irq}), z(8'h00));
    rdchk(PEMASK_IDX_IRQSTAT, 8'h00);
    rdchk(PEMASK_IDX_FALL18, 8'h00);
    rdchk(PEMASK_IDX_RISE18, 8'h00);
    rdchk(PEMASK_IDX_PIN910, 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_nvm();
    t_edges();
    t_midreset();
    summarize();
  end
endmodule // pin_edge_irq_masking_test
`default_nettype wire
